// *** design/prs_panel.sv ***
// Front-panel sequencer: selector switch, status LEDs, extended reset dialogue, battery check.
// Assumes raw switch contacts and battery comparator are asynchronous pins; program status
// inputs come from the controller on the same clock.
`timescale 1ns/1ps
// Notes on behaviour
// - Error state blinks error LED, one second period
// - Stop state holds stop LED lit
// - Run LED off after inputs, on before outputs
// - Stop state keeps run LED off
// - Stop position suspends cyclic execution
// - Run position enables cyclic execution
// - Reset position resets controller then runs
// - Function one erases all data blocks
// - Function two erases project, loads stored one
// - Over five second press lights long-press LED
// - One press selects one, two select two
// - LED off, then one or two acknowledge flashes
// - After twenty seconds, LED steady ten seconds
// - Execute only on press within confirmation window
// - Short press or timeout gives normal reset
// - Power-on low battery reports option error
module prs_panel #(
    parameter int unsigned TICK_CYCLES = prs_pkg::TICK_CYCLES,
    parameter int unsigned LONG_TICKS = prs_pkg::LONG_PRESS_MS / prs_pkg::TICK_MS,
    parameter int unsigned SELECT_TICKS = prs_pkg::SELECT_MS / prs_pkg::TICK_MS,
    parameter int unsigned CONFIRM_TICKS = prs_pkg::CONFIRM_MS / prs_pkg::TICK_MS,
    parameter int unsigned BLINK_TICKS = prs_pkg::ERR_BLINK_MS / prs_pkg::TICK_MS,
    parameter int unsigned FLASH_TICKS = prs_pkg::ACK_FLASH_MS / prs_pkg::TICK_MS,
    parameter int unsigned DEB_TICKS = prs_pkg::DEBOUNCE_MS / prs_pkg::TICK_MS
) (
    input wire logic core_clk_in,
    input wire logic rst_b_in,
    input wire logic stop_sw_in,
    input wire logic run_sw_in,
    input wire logic reset_sw_in,
    input wire logic batt_low_in,
    input wire logic fault_in,
    input wire logic inputs_formed_in,
    input wire logic outputs_send_in,
    input wire logic load_done_in,
    output logic execute_en_out,
    output logic ctrl_reset_out,
    output logic erase_blocks_out,
    output logic erase_project_out,
    output logic error_led_out,
    output logic stop_led_out,
    output logic run_led_out,
    output logic long_press_led_out,
    output logic opt_err_valid_out,
    output logic [15:0] opt_err_code_out,
    output logic [7:0] opt_err_module_out,
    output logic [7:0] opt_err_number_out
);
    initial begin
        if (LONG_TICKS < 2 || SELECT_TICKS < 2 || CONFIRM_TICKS < 2 || FLASH_TICKS < 1) begin
            $error("prs_panel: timing parameters too small");
        end
    end
    localparam int CW = $clog2(SELECT_TICKS + LONG_TICKS + CONFIRM_TICKS + 1);
    localparam logic [CW-1:0] C_ONE = CW'(1);

    typedef enum logic [2:0] {
        PRS_IDLE,
        PRS_HOLD,
        PRS_WAIT_REL,
        PRS_SELECT,
        PRS_CONFIRM,
        PRS_EXEC,
        PRS_RESTART
    } prs_seq_type;

    // ==========================================================
    // Reset release and pin synchronisers
    logic [1:0] rst_sync_r;
    logic rst_b;
    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_b = rst_sync_r[1];

    logic [3:0] pin_s1_r, pin_s2_r;
    always_ff @(posedge core_clk_in or negedge rst_b) begin
        if (!rst_b) begin
            pin_s1_r <= 4'h0;
            pin_s2_r <= 4'h0;
        end else begin
            pin_s1_r <= {batt_low_in, reset_sw_in, run_sw_in, stop_sw_in};
            pin_s2_r <= pin_s1_r;
        end
    end

    // ==========================================================
    // Debounce and blink helpers
    prs_sw_if sw ();
    prs_debounce #(.TICK_CYCLES(TICK_CYCLES), .DEB_TICKS(DEB_TICKS)) u_deb (
        .clk_in(core_clk_in),
        .rst_b_in(rst_b),
        .raw_in(pin_s2_r[2:0]),
        .sw(sw)
    );

    prs_pkg::prs_plc_type plc_r, plc_nxt;
    logic blink_wave;
    prs_blink #(.PERIOD_TICKS(BLINK_TICKS)) u_blink (
        .clk_in(core_clk_in),
        .rst_b_in(rst_b),
        .enable_in(plc_r == prs_pkg::PRS_PLC_ERROR),
        .tick_in(sw.tick),
        .wave_out(blink_wave)
    );

    // ==========================================================
    // Sequencer state
    prs_seq_type seq_r, seq_nxt;
    logic [CW-1:0] cnt_r, cnt_nxt;
    logic [1:0] presses_r, presses_nxt;
    logic [2:0] flash_r, flash_nxt;
    logic [CW-1:0] fcnt_r, fcnt_nxt;
    logic rs_prev_r, rs_prev_nxt;
    logic ctrl_reset_r, ctrl_reset_nxt;
    logic erase_blk_r, erase_blk_nxt;
    logic erase_prj_r, erase_prj_nxt;
    logic lo_led_r, lo_led_nxt;
    logic exec_r, exec_nxt;
    logic err_led_r, err_led_nxt;
    logic stop_led_r, stop_led_nxt;
    logic run_led_r, run_led_nxt;
    logic batt_done_r, batt_done_nxt;
    logic batt_err_r, batt_err_nxt;
    logic press;

    assign press = sw.reset_pos && !rs_prev_r;

    // Dialogue, state and LED next values
    always_comb begin
        seq_nxt = seq_r;
        cnt_nxt = cnt_r;
        presses_nxt = presses_r;
        flash_nxt = flash_r;
        fcnt_nxt = fcnt_r;
        rs_prev_nxt = sw.reset_pos;
        ctrl_reset_nxt = 1'b0;
        erase_blk_nxt = 1'b0;
        erase_prj_nxt = 1'b0;
        lo_led_nxt = 1'b0;
        plc_nxt = plc_r;
        batt_done_nxt = batt_done_r | sw.tick;
        batt_err_nxt = batt_err_r;
        // Battery followed until the first tick; the synchroniser holds its reset value only for the first two cycles
        if (!batt_done_r) begin
            batt_err_nxt = pin_s2_r[3];
        end
        unique case (seq_r)
            PRS_IDLE: begin
                cnt_nxt = '0;
                if (press) begin
                    seq_nxt = PRS_HOLD;
                end
            end
            PRS_HOLD: begin
                if (sw.tick && cnt_r != CW'(LONG_TICKS)) begin
                    cnt_nxt = cnt_r + C_ONE;
                end
                if (cnt_r == CW'(LONG_TICKS)) begin
                    lo_led_nxt = 1'b1;
                end
                if (!sw.reset_pos) begin
                    cnt_nxt = '0;
                    presses_nxt = 2'h0;
                    // Short press only restarts
                    seq_nxt = (cnt_r == CW'(LONG_TICKS)) ? PRS_SELECT : PRS_RESTART;
                end
            end
            PRS_SELECT: begin
                // Count presses inside the selection interval
                if (sw.tick) begin
                    cnt_nxt = cnt_r + C_ONE;
                end
                if (press && presses_r != 2'h2) begin
                    presses_nxt = presses_r + 2'h1;
                    flash_nxt = {1'b0, presses_r + 2'h1} << 1;
                    fcnt_nxt = '0;
                end
                if (flash_r != 3'h0) begin
                    lo_led_nxt = flash_r[0];
                    if (sw.tick) begin
                        fcnt_nxt = fcnt_r + C_ONE;
                        if (fcnt_r == CW'(FLASH_TICKS - 1)) begin
                            fcnt_nxt = '0;
                            flash_nxt = flash_r - 3'h1;
                        end
                    end
                end
                if (cnt_r == CW'(SELECT_TICKS)) begin
                    cnt_nxt = '0;
                    flash_nxt = 3'h0;
                    seq_nxt = (presses_r == 2'h0) ? PRS_RESTART : PRS_CONFIRM;
                end
            end
            PRS_CONFIRM: begin
                lo_led_nxt = 1'b1;
                if (sw.tick) begin
                    cnt_nxt = cnt_r + C_ONE;
                end
                if (press) begin
                    seq_nxt = PRS_EXEC;
                end else if (cnt_r == CW'(CONFIRM_TICKS)) begin
                    seq_nxt = PRS_RESTART;
                end
            end
            PRS_EXEC: begin
                erase_blk_nxt = (presses_r == 2'h1);
                erase_prj_nxt = (presses_r == 2'h2);
                seq_nxt = PRS_RESTART;
            end
            PRS_RESTART: begin
                ctrl_reset_nxt = 1'b1;
                if (!sw.reset_pos) begin
                    seq_nxt = PRS_IDLE;
                end
            end
            default: begin
                seq_nxt = PRS_IDLE;
            end
        endcase
        // Controller state from selector and faults
        if (ctrl_reset_r || seq_r != PRS_IDLE) begin
            plc_nxt = prs_pkg::PRS_PLC_RESET;
        end else if (fault_in || batt_err_r) begin
            plc_nxt = prs_pkg::PRS_PLC_ERROR;
        end else if (sw.stop_pos) begin
            plc_nxt = prs_pkg::PRS_PLC_STOP;
        end else if (sw.run_pos) begin
            plc_nxt = prs_pkg::PRS_PLC_RUN;
        end
        exec_nxt = (plc_nxt == prs_pkg::PRS_PLC_RUN);
        err_led_nxt = (plc_r == prs_pkg::PRS_PLC_ERROR) && blink_wave;
        stop_led_nxt = (plc_r == prs_pkg::PRS_PLC_STOP);
        // Duty of the run LED tracks the scan cycle
        run_led_nxt = run_led_r;
        if (plc_r != prs_pkg::PRS_PLC_RUN) begin
            run_led_nxt = 1'b0;
        end else if (outputs_send_in) begin
            run_led_nxt = 1'b1;
        end else if (inputs_formed_in) begin
            run_led_nxt = 1'b0;
        end
    end

    // Registers
    always_ff @(posedge core_clk_in or negedge rst_b) begin
        if (!rst_b) begin
            seq_r <= PRS_IDLE;
            cnt_r <= '0;
            presses_r <= 2'h0;
            flash_r <= 3'h0;
            fcnt_r <= '0;
            rs_prev_r <= 1'b0;
            ctrl_reset_r <= 1'b0;
            erase_blk_r <= 1'b0;
            erase_prj_r <= 1'b0;
            lo_led_r <= 1'b0;
            plc_r <= prs_pkg::PRS_PLC_STOP;
            exec_r <= 1'b0;
            err_led_r <= 1'b0;
            stop_led_r <= 1'b0;
            run_led_r <= 1'b0;
            batt_done_r <= 1'b0;
            batt_err_r <= 1'b0;
        end else begin
            seq_r <= seq_nxt;
            cnt_r <= cnt_nxt;
            presses_r <= presses_nxt;
            flash_r <= flash_nxt;
            fcnt_r <= fcnt_nxt;
            rs_prev_r <= rs_prev_nxt;
            ctrl_reset_r <= ctrl_reset_nxt;
            erase_blk_r <= erase_blk_nxt;
            erase_prj_r <= erase_prj_nxt;
            lo_led_r <= lo_led_nxt;
            plc_r <= plc_nxt;
            exec_r <= exec_nxt;
            err_led_r <= err_led_nxt;
            stop_led_r <= stop_led_nxt;
            run_led_r <= run_led_nxt;
            batt_done_r <= batt_done_nxt;
            batt_err_r <= batt_err_nxt;
        end
    end

    // ==========================================================
    // Outputs
    assign execute_en_out = exec_r;
    assign ctrl_reset_out = ctrl_reset_r;
    assign erase_blocks_out = erase_blk_r;
    assign erase_project_out = erase_prj_r;
    assign error_led_out = err_led_r;
    assign stop_led_out = stop_led_r;
    assign run_led_out = run_led_r;
    assign long_press_led_out = lo_led_r;
    assign opt_err_valid_out = batt_err_r;
    assign opt_err_code_out = batt_err_r ? prs_pkg::BATT_ERR_CODE : prs_pkg::NO_ERR_CODE;
    assign opt_err_module_out = batt_err_r ? prs_pkg::BATT_ERR_MODULE : prs_pkg::NO_ERR_BYTE;
    assign opt_err_number_out = batt_err_r ? prs_pkg::BATT_ERR_NUMBER : prs_pkg::NO_ERR_BYTE;

    // ==========================================================
    // Assertions
    property p_stop_led;
        @(posedge core_clk_in) disable iff (!rst_b)
        plc_r == prs_pkg::PRS_PLC_STOP |=> stop_led_r && !run_led_r;
    endproperty
    a_stop_led: assert property (p_stop_led) else $error("stop led wrong");

    property p_run_off;
        @(posedge core_clk_in) disable iff (!rst_b)
        plc_r != prs_pkg::PRS_PLC_RUN |=> !run_led_r;
    endproperty
    a_run_off: assert property (p_run_off) else $error("run led lit outside run");

    property p_run_set;
        @(posedge core_clk_in) disable iff (!rst_b)
        plc_r == prs_pkg::PRS_PLC_RUN && outputs_send_in |=> run_led_r;
    endproperty
    a_run_set: assert property (p_run_set) else $error("run led not set");

    property p_exec;
        @(posedge core_clk_in) disable iff (!rst_b)
        sw.stop_pos |=> !exec_r;
    endproperty
    a_exec: assert property (p_exec) else $error("execution outside run");

    property p_erase_confirm;
        @(posedge core_clk_in) disable iff (!rst_b)
        $rose(erase_blk_r) || $rose(erase_prj_r) |-> $past(seq_r, 2) == PRS_CONFIRM;
    endproperty
    a_erase_confirm: assert property (p_erase_confirm) else $error("erase without confirm");

    property p_erase_restart;
        @(posedge core_clk_in) disable iff (!rst_b)
        erase_blk_r || erase_prj_r |=> ctrl_reset_r;
    endproperty
    a_erase_restart: assert property (p_erase_restart) else $error("no reset after erase");

    property p_confirm_led;
        @(posedge core_clk_in) disable iff (!rst_b)
        seq_r == PRS_CONFIRM |=> lo_led_r;
    endproperty
    a_confirm_led: assert property (p_confirm_led) else $error("long led not steady");

    property p_idle_led;
        @(posedge core_clk_in) disable iff (!rst_b)
        seq_r == PRS_IDLE |=> !lo_led_r;
    endproperty
    a_idle_led: assert property (p_idle_led) else $error("long led lit at idle");

    property p_single_erase;
        @(posedge core_clk_in) disable iff (!rst_b)
        !(erase_blk_r && erase_prj_r);
    endproperty
    a_single_erase: assert property (p_single_erase) else $error("both erases at once");
endmodule

// *** design/prs_pkg.sv ***
// Constants shared by the panel reset sequencer modules.
// Assumes a single system clock; times are given in milliseconds and converted to ticks by the modules using them.
package prs_pkg;
    // ==========================================================
    // Clock and time base
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned TICK_MS = 1;
    localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
    // ==========================================================
    // Operator timings in milliseconds
    localparam int unsigned LONG_PRESS_MS = 5000;
    localparam int unsigned SELECT_MS = 20000;
    localparam int unsigned CONFIRM_MS = 10000;
    localparam int unsigned ERR_BLINK_MS = 1000;
    localparam int unsigned ACK_FLASH_MS = 250;
    localparam int unsigned DEBOUNCE_MS = 20;
    localparam int unsigned RESET_PULSE_MS = 1;
    // ==========================================================
    // Battery error report
    localparam logic [15:0] BATT_ERR_CODE = 16'h0B00;
    localparam logic [7:0] BATT_ERR_MODULE = 8'h78;
    localparam logic [7:0] BATT_ERR_NUMBER = 8'h01;
    localparam logic [15:0] NO_ERR_CODE = 16'h0000;
    localparam logic [7:0] NO_ERR_BYTE = 8'h00;
    // ==========================================================
    // Controller states shown on the panel
    typedef enum logic [1:0] {
        PRS_PLC_STOP,
        PRS_PLC_RUN,
        PRS_PLC_ERROR,
        PRS_PLC_RESET
    } prs_plc_type;
endpackage

// *** design/prs_sw_if.sv ***
// Debounced selector positions passed from the debouncer to the sequencer.
// Assumes both ends share the system clock.
`timescale 1ns/1ps
interface prs_sw_if;
    logic stop_pos;
    logic run_pos;
    logic reset_pos;
    logic tick;
    modport src (output stop_pos, output run_pos, output reset_pos, output tick);
    modport dst (input stop_pos, input run_pos, input reset_pos, input tick);
endinterface

// *** design/prs_debounce.sv ***
// Millisecond tick generator and debouncer for the three switch contacts.
// Assumes its inputs are already synchronised to the system clock.
`timescale 1ns/1ps
module prs_debounce #(
    parameter int unsigned TICK_CYCLES = prs_pkg::TICK_CYCLES,
    parameter int unsigned DEB_TICKS = prs_pkg::DEBOUNCE_MS
) (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic [2:0] raw_in,
    prs_sw_if.src sw
);
    initial begin
        if (TICK_CYCLES < 2 || DEB_TICKS < 1) begin
            $error("prs_debounce: bad parameters");
        end
    end
    localparam int DW = $clog2(TICK_CYCLES + 1);
    localparam int BW = $clog2(DEB_TICKS + 1);
    logic [DW-1:0] div_r, div_nxt;
    logic tick_r, tick_nxt;
    logic [2:0] stable_r, stable_nxt;
    logic [BW-1:0] cnt_r [3];
    logic [BW-1:0] cnt_nxt [3];

    // ==========================================================
    // Tick and debounce next state
    always_comb begin
        div_nxt = div_r + DW'(1);
        tick_nxt = 1'b0;
        if (div_r == DW'(TICK_CYCLES - 1)) begin
            div_nxt = '0;
            tick_nxt = 1'b1;
        end
        stable_nxt = stable_r;
        for (int i = 0; i < 3; i++) begin
            cnt_nxt[i] = cnt_r[i];
            // Contact must stay changed for the whole window, bounce restarts it
            if (raw_in[i] == stable_r[i]) begin
                cnt_nxt[i] = '0;
            end else if (tick_r) begin
                if (cnt_r[i] == BW'(DEB_TICKS - 1)) begin
                    stable_nxt[i] = raw_in[i];
                    cnt_nxt[i] = '0;
                end else begin
                    cnt_nxt[i] = cnt_r[i] + BW'(1);
                end
            end
        end
    end

    // Registers
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            div_r <= '0;
            tick_r <= 1'b0;
            stable_r <= '0; // No position until seen stable, avoids a false run after reset
            for (int i = 0; i < 3; i++) begin
                cnt_r[i] <= '0;
            end
        end else begin
            div_r <= div_nxt;
            tick_r <= tick_nxt;
            stable_r <= stable_nxt;
            for (int i = 0; i < 3; i++) begin
                cnt_r[i] <= cnt_nxt[i];
            end
        end
    end

    assign sw.stop_pos = stable_r[0];
    assign sw.run_pos = stable_r[1];
    assign sw.reset_pos = stable_r[2];
    assign sw.tick = tick_r;
endmodule

// *** design/prs_blink.sv ***
// Square wave generator on the millisecond tick, used for the error blink.
// Assumes the tick is a one-cycle pulse on the system clock.
`timescale 1ns/1ps
module prs_blink #(
    parameter int unsigned PERIOD_TICKS = prs_pkg::ERR_BLINK_MS
) (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic enable_in,
    input wire logic tick_in,
    output logic wave_out
);
    initial begin
        if (PERIOD_TICKS < 2 || PERIOD_TICKS % 2 != 0) begin
            $error("prs_blink: period must be even and at least 2");
        end
    end
    localparam int W = $clog2(PERIOD_TICKS);
    logic [W-1:0] cnt_r, cnt_nxt;
    logic wave_r, wave_nxt;

    // ==========================================================
    // Half period toggling, restarts lit whenever disabled
    always_comb begin
        cnt_nxt = cnt_r;
        wave_nxt = wave_r;
        if (!enable_in) begin
            cnt_nxt = '0;
            wave_nxt = 1'b1;
        end else if (tick_in) begin
            if (cnt_r == W'(PERIOD_TICKS / 2 - 1)) begin
                cnt_nxt = '0;
                wave_nxt = ~wave_r;
            end else begin
                cnt_nxt = cnt_r + W'(1);
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            cnt_r <= '0;
            wave_r <= 1'b1;
        end else begin
            cnt_r <= cnt_nxt;
            wave_r <= wave_nxt;
        end
    end

    assign wave_out = wave_r;
endmodule

// *** bench/prs_operator.sv ***
// Operator model: drives the three selector contacts of the panel.
// Assumes its tasks are entered just after a rising clock edge.
`timescale 1ns/1ps
module prs_operator (
    input wire logic clk_in,
    output logic stop_sw_out,
    output logic run_sw_out,
    output logic reset_sw_out
);
    // ====================
    // Contacts, lever starts in stop
    initial begin
        stop_sw_out = 1'h1;
        run_sw_out = 1'h0;
        reset_sw_out = 1'h0;
    end
    // Wait n edges, then step off the edge
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_in);
        #10;
    endtask
    // Latched lever position; one contact closed at a time
    task automatic lever(input logic stop);
        stop_sw_out = stop;
        run_sw_out = ~stop;
    endtask
    // Hold reset n cycles with contact bounce, then back to run
    task automatic press(input int n);
        stop_sw_out = 1'h0;
        run_sw_out = 1'h0;
        // Bounce is far shorter than the debounce time, so it must not count
        repeat (3) begin
            reset_sw_out = 1'h1;
            cyc(1);
            reset_sw_out = 1'h0;
            cyc(1);
        end
        reset_sw_out = 1'h1;
        cyc(n);
        reset_sw_out = 1'h0;
        run_sw_out = 1'h1;
    endtask
endmodule

// *** bench/test_panel_reset_sequencer.sv ***
// Bench for the panel sequencer: operator model, scan pulses and checks.
// Assumes shortened timings; one tick is ten clock cycles.
`timescale 1ns/1ps
module test_panel_reset_sequencer;
    logic clk, rst_b, batt_low, fault, formed, send, load_done;
    logic stop_sw, run_sw, reset_sw;
    logic exe, crst, ers_b, ers_p, err_led, stop_led, run_led, long_led, ov;
    logic [15:0] oc;
    logic [7:0] om, onum;
    int mismatches = 0;
    int n_tests = 0;
    int n_crst = 0;
    int n_lp = 0;
    int n_eb = 0;
    int n_ep = 0;
    // ====================
    // Clock and watchdog; the tests need a few thousand cycles
    initial begin
        clk = 1'h0;
        forever #50 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        summarize();
    end
    // Event counters for pulses and rising levels
    always @(posedge clk) begin
        if ($rose(crst)) n_crst++;
        if ($rose(long_led)) n_lp++;
        if (ers_b === 1'h1) n_eb++;
        if (ers_p === 1'h1) n_ep++;
    end
    prs_panel #(.TICK_CYCLES(10), .LONG_TICKS(8), .SELECT_TICKS(20), .CONFIRM_TICKS(10),
        .BLINK_TICKS(4), .FLASH_TICKS(1), .DEB_TICKS(2)) dut_u (
        .core_clk_in(clk), .rst_b_in(rst_b), .stop_sw_in(stop_sw), .run_sw_in(run_sw),
        .reset_sw_in(reset_sw), .batt_low_in(batt_low), .fault_in(fault),
        .inputs_formed_in(formed), .outputs_send_in(send), .load_done_in(load_done),
        .execute_en_out(exe), .ctrl_reset_out(crst), .erase_blocks_out(ers_b),
        .erase_project_out(ers_p), .error_led_out(err_led), .stop_led_out(stop_led),
        .run_led_out(run_led), .long_press_led_out(long_led), .opt_err_valid_out(ov),
        .opt_err_code_out(oc), .opt_err_module_out(om), .opt_err_number_out(onum));
    prs_operator op_u (.clk_in(clk), .stop_sw_out(stop_sw), .run_sw_out(run_sw),
        .reset_sw_out(reset_sw));
    // ====================
    // Compare tasks
    task automatic chk1(input string name, input logic exp, input logic got);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %b seen %b", name, exp, got);
        end
    endtask
    task automatic chkv(input string name, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic summarize;
        if (mismatches == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // ====================
    // Scenarios
    // Low battery at power-on, then a second power-on with a good battery
    task automatic t_power;
        op_u.cyc(50);
        chk1("opt_err_valid", 1'h1, ov);
        chkv("opt_err_code", 16'h0B00, oc);
        chkv("opt_err_module", 16'h0078, {8'h00, om});
        chkv("opt_err_number", 16'h0001, {8'h00, onum});
        chk1("stop_led_batt", 1'h0, stop_led);
        rst_b = 1'h0;
        batt_low = 1'h0;
        op_u.cyc(4);
        rst_b = 1'h1;
        op_u.cyc(50);
        chk1("opt_err_clear", 1'h0, ov);
        chkv("opt_err_code_clear", 16'h0000, oc);
        chk1("stop_led", 1'h1, stop_led);
        chk1("run_led_stop", 1'h0, run_led);
        chk1("exec_stop", 1'h0, exe);
    endtask
    // Run LED follows the scan pulses; stop keeps it off and stops execution
    task automatic t_run;
        op_u.lever(1'h0);
        op_u.cyc(40);
        chk1("exec_run", 1'h1, exe);
        send = 1'h1;
        op_u.cyc(1);
        send = 1'h0;
        op_u.cyc(2);
        chk1("run_led_send", 1'h1, run_led);
        formed = 1'h1;
        op_u.cyc(1);
        formed = 1'h0;
        op_u.cyc(2);
        chk1("run_led_formed", 1'h0, run_led);
        op_u.lever(1'h1);
        op_u.cyc(40);
        chk1("run_led_off", 1'h0, run_led);
        chk1("exec_off", 1'h0, exe);
        op_u.lever(1'h0);
        op_u.cyc(40);
    endtask
    task automatic t_short;
        int c;
        int lp;
        c = n_crst;
        lp = n_lp;
        op_u.press(30);
        op_u.cyc(60);
        chkv("ctrl_resets", 16'(c + 1), 16'(n_crst));
        chkv("long_rises", 16'(lp), 16'(n_lp));
        chk1("exec_restart", 1'h1, exe);
    endtask
    // Long press, k selections, then confirm or let the windows run out
    task automatic t_ext(input int k, input logic confirm);
        int eb;
        int ep;
        int lp;
        eb = n_eb;
        ep = n_ep;
        op_u.press(130);
        chk1("long_led_lit", 1'h1, long_led);
        lp = n_lp;
        repeat (k) begin
            op_u.cyc(30);
            op_u.press(30);
        end
        op_u.cyc(50);
        chk1("ack_flashes", 1'h1, k == 1 ? n_lp - lp == 1 : n_lp - lp >= 2);
        op_u.cyc(200 - 66 * k);
        chk1("confirm_led", 1'h1, long_led);
        chkv("early_erase", 16'(eb + ep), 16'(n_eb + n_ep));
        if (confirm) begin
            op_u.press(30);
            op_u.cyc(20);
        end else begin
            op_u.cyc(200);
        end
        chkv("erase_blocks", 16'(eb + (confirm && k == 1)), 16'(n_eb));
        chkv("erase_project", 16'(ep + (confirm && k == 2)), 16'(n_ep));
        op_u.cyc(60);
        chk1("exec_after", 1'h1, exe);
    endtask
    // Error LED toggles every two ticks of the shortened timebase
    task automatic t_fault;
        int t;
        logic p;
        t = 0;
        fault = 1'h1;
        op_u.cyc(5);
        p = err_led;
        repeat (200) begin
            op_u.cyc(1);
            if (err_led !== p) t++;
            p = err_led;
        end
        chk1("err_blink", 1'h1, t >= 9 && t <= 11);
        fault = 1'h0;
    endtask
    // ====================
    // Main sequence
    initial begin
        rst_b = 1'h0;
        batt_low = 1'h1;
        fault = 1'h0;
        formed = 1'h0;
        send = 1'h0;
        load_done = 1'h0;
        repeat (4) @(posedge clk);
        #10;
        rst_b = 1'h1;
        t_power();
        t_run();
        t_short();
        t_ext(1, 1'h1);
        t_ext(2, 1'h1);
        t_ext(1, 1'h0);
        t_fault();
        summarize();
    end
endmodule
